/* logic/hps_pkg.sv */
// constants, types and port indices shared by the host port select logic
// assumes one core clock at CLK_FREQ_HZ; all host pins arrive asynchronously
// Summary of operation
// RULE_01: four shared pins: UART plus I2C, or SPI
// RULE_02: TX/MISO, RX/MOSI, SCL/SCK, SDA/CS_N pin sharing
// RULE_03: board ties select low for SPI, open for UART
// RULE_04: SPI selected keeps UART and I2C inactive
// RULE_05: one pending-transmit indicator per port, never shared
// RULE_06: indicator polarity and byte threshold are configurable
// RULE_07: indicator function disabled after reset
// RULE_08: UART rate configurable, 9600 baud default
// RULE_09: UART asynchronous only, no flow control lines
// RULE_10: RX level change wakes from power save
// RULE_11: pull-ups enabled on all digital pins
// RULE_12: event input off after reset, else spare I/O
// RULE_13: configured event input wakes and marks time
// RULE_14: on/off switching removes event input pull-up
// RULE_15: amplifier duty-cycled, or off in backup
// RULE_16: indicator drops when count falls below threshold
package hps_pkg;

  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int UART_BAUD_DEFAULT = 9600;
  localparam int BAUD_DIV_W = 16;
  localparam int UART_BAUD_DIV_DEFAULT = CLK_FREQ_HZ / UART_BAUD_DEFAULT;

  localparam int TX_COUNT_W = 8;

  // host ports, each owning one indicator
  localparam int PORT_UART = 0;
  localparam int PORT_I2C = 1;
  localparam int PORT_SPI = 2;
  localparam int NUM_PORTS = 3;

  // synchroniser lanes: rx/mosi, scl/sck, sda/cs_n, event input, select strap
  localparam int SY_RX = 0;
  localparam int SY_CK = 1;
  localparam int SY_SD = 2;
  localparam int SY_EV = 3;
  localparam int SY_SEL = 4;
  localparam int SY_W = 5;

  typedef enum logic [1:0] {EXT_OFF, EXT_WAKE, EXT_ONOFF} hps_ext_e;
  typedef enum logic [1:0] {PWR_CONTINUOUS, PWR_DUTY, PWR_BACKUP} hps_pwr_e;

endpackage

/* logic/hps_txr_if.sv */
// carries one port's pending-transmit settings and the indicator pin state
// assumes the top drives configuration and reads back the registered pin
`timescale 1ns/10ps
interface hps_txr_if #(parameter int CW = 8);
  logic enable;
  logic polarity;
  logic port_on;
  logic [CW-1:0] threshold;
  logic [CW-1:0] count;
  logic level;
  logic drive_n;
  modport ctl(output enable, output polarity, output port_on, output threshold, output count,
              input level, input drive_n);
  modport ind(input enable, input polarity, input port_on, input threshold, input count,
              output level, output drive_n);
endinterface

/* logic/hps_txready.sv */
// pending-transmit indicator for one host port
// assumes count is the port's buffered outgoing byte count on ref_clk
`timescale 1ns/10ps
module hps_txready
  import hps_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // settings in, pin state out
  hps_txr_if.ind txr
);

  logic pending;
  logic en_q;

  // only real data counts, so a zero threshold still needs one byte
  assign pending = (txr.count != '0) && (txr.count >= txr.threshold); // RULE_06 RULE_16

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      en_q <= 1'b0; // RULE_07
      txr.level <= 1'b1;
      txr.drive_n <= 1'b1;
    end else begin
      en_q <= txr.enable && txr.port_on;
      // released pin keeps its pull-up while the function is off
      txr.drive_n <= ~en_q; // RULE_05
      txr.level <= pending ? txr.polarity : ~txr.polarity; // RULE_06 RULE_16
    end
  end

endmodule

/* logic/hps_port_select.sv */
// host pin sharing, pin wake, event input and amplifier enable
// assumes serial cores sit behind the core-side ports; pins are asynchronous,
// the SPI/I2C clock pin is oversampled by ref_clk
`timescale 1ns/10ps
module hps_port_select
  import hps_pkg::*;
#(
  parameter int CW = TX_COUNT_W,
  parameter logic [BAUD_DIV_W-1:0] BAUD_DIV_RESET = BAUD_DIV_W'(UART_BAUD_DIV_DEFAULT)
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // interface select strap, high for UART plus I2C
  input wire logic iface_sel_i,
  // shared host pins
  output logic pin_txd_o,
  output logic pin_txd_oe_n,
  input wire logic pin_rxd_i,
  input wire logic pin_clk_i,
  input wire logic pin_sda_i,
  output logic pin_sda_o,
  output logic pin_sda_oe_n,
  output logic [3:0] pin_pullup_en,
  // core side: UART
  input wire logic uart_tx,
  output logic uart_rx,
  output logic uart_active,
  input wire logic baud_wr,
  input wire logic [BAUD_DIV_W-1:0] baud_div_in,
  output logic [BAUD_DIV_W-1:0] baud_div,
  // core side: I2C-compatible channel
  input wire logic i2c_sda_pull_low,
  output logic i2c_scl,
  output logic i2c_sda,
  output logic i2c_active,
  // core side: SPI slave
  input wire logic spi_miso,
  output logic spi_mosi,
  output logic spi_sck,
  output logic spi_sck_rise,
  output logic spi_sck_fall,
  output logic spi_cs_n,
  output logic spi_active,
  // pending-transmit indicators, one per port
  input wire logic [NUM_PORTS-1:0] txr_enable,
  input wire logic [NUM_PORTS-1:0] txr_polarity,
  input wire logic [NUM_PORTS*CW-1:0] txr_threshold,
  input wire logic [NUM_PORTS*CW-1:0] tx_count,
  output logic [NUM_PORTS-1:0] txr_pin_o,
  output logic [NUM_PORTS-1:0] txr_pin_oe_n,
  // power state and wake
  input wire logic power_save,
  input wire logic [1:0] power_mode,
  input wire logic rf_on,
  output logic wake_req,
  output logic amplifier_enable,
  // external event input and spare general I/O on the same pin
  input wire logic [1:0] ext_mode,
  input wire logic external_event_input_i,
  output logic external_event_input_o,
  output logic external_event_input_oe_n,
  output logic external_event_input_pullup_en,
  output logic event_mark,
  input wire logic spare_general_io_out,
  input wire logic spare_general_io_drive,
  output logic spare_general_io_in
);

  logic [SY_W-1:0] sync1_q;
  logic [SY_W-1:0] sync2_q;
  logic [SY_W-1:0] sync3_q;
  logic strap_taken_q;
  logic sel_uart_q;
  logic [BAUD_DIV_W-1:0] baud_div_q;

  wire logic mode_uart;
  wire logic mode_spi;
  wire logic ck_rise;
  wire logic ck_fall;
  wire logic rx_change;
  wire logic ev_edge;
  wire logic ev_used;
  wire logic amp_d;
  wire logic spi_sel_now;
  wire logic txd_d;
  wire logic txd_oe_n_d;
  wire logic sda_oe_n_d;
  wire logic ev_oe_n_d;

  // both modes stay quiet until the strap has been caught
  assign mode_uart = strap_taken_q && sel_uart_q; // RULE_01 RULE_03
  assign mode_spi = strap_taken_q && !sel_uart_q; // RULE_01 RULE_03
  assign ck_rise = sync2_q[SY_CK] && !sync3_q[SY_CK];
  assign ck_fall = !sync2_q[SY_CK] && sync3_q[SY_CK];
  assign rx_change = sync2_q[SY_RX] != sync3_q[SY_RX];
  assign ev_used = (ext_mode == EXT_WAKE) || (ext_mode == EXT_ONOFF);
  assign ev_edge = ev_used && (sync2_q[SY_EV] != sync3_q[SY_EV]);
  assign spi_sel_now = mode_spi && !sync2_q[SY_SD];
  assign amp_d = (power_mode == PWR_CONTINUOUS) ? 1'b1 :
                 (power_mode == PWR_DUTY) ? rf_on : 1'b0; // RULE_15
  assign txd_d = mode_uart ? uart_tx : spi_miso; // RULE_02
  assign txd_oe_n_d = !(mode_uart || spi_sel_now); // RULE_02
  // open drain: only the I2C core pulls the data pin, and only ever low
  assign sda_oe_n_d = !(mode_uart && i2c_sda_pull_low); // RULE_02
  assign ev_oe_n_d = !(!ev_used && spare_general_io_drive); // RULE_12

  always_ff @(posedge ref_clk) begin
    sync1_q <= {iface_sel_i, external_event_input_i, pin_sda_i, pin_clk_i, pin_rxd_i};
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
  end

  // strap is sampled once after reset release; a moving select pin is ignored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strap_taken_q <= 1'b0;
      sel_uart_q <= 1'b1;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      sel_uart_q <= sync2_q[SY_SEL]; // RULE_03
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      baud_div_q <= BAUD_DIV_RESET; // RULE_08
    end else if (baud_wr) begin
      baud_div_q <= baud_div_in; // RULE_08
    end
  end

  // shared pins; every output is registered so pin timing is one cycle late
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_txd_o <= 1'b1;
      pin_txd_oe_n <= 1'b1;
      pin_sda_o <= 1'b0;
      pin_sda_oe_n <= 1'b1;
      pin_pullup_en <= 4'hF;
    end else begin
      pin_txd_o <= txd_d; // RULE_02
      pin_txd_oe_n <= txd_oe_n_d; // RULE_02
      pin_sda_o <= 1'b0;
      pin_sda_oe_n <= sda_oe_n_d; // RULE_02
      pin_pullup_en <= 4'hF; // RULE_11
    end
  end

  // core side; a deselected core sees idle levels
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      uart_rx <= 1'b1;
      uart_active <= 1'b0;
      baud_div <= BAUD_DIV_RESET;
      i2c_scl <= 1'b1;
      i2c_sda <= 1'b1;
      i2c_active <= 1'b0;
      spi_mosi <= 1'b0;
      spi_sck <= 1'b0;
      spi_sck_rise <= 1'b0;
      spi_sck_fall <= 1'b0;
      spi_cs_n <= 1'b1;
      spi_active <= 1'b0;
    end else begin
      // UART carries only data lines: no handshake, no clocked mode
      uart_rx <= mode_uart ? sync2_q[SY_RX] : 1'b1; // RULE_09 RULE_04
      uart_active <= mode_uart; // RULE_04
      baud_div <= baud_div_q;
      i2c_scl <= mode_uart ? sync2_q[SY_CK] : 1'b1; // RULE_02 RULE_04
      i2c_sda <= mode_uart ? sync2_q[SY_SD] : 1'b1; // RULE_02 RULE_04
      i2c_active <= mode_uart; // RULE_04
      spi_mosi <= mode_spi ? sync2_q[SY_RX] : 1'b0; // RULE_02
      spi_sck <= mode_spi ? sync2_q[SY_CK] : 1'b0; // RULE_02
      spi_sck_rise <= spi_sel_now && ck_rise;
      spi_sck_fall <= spi_sel_now && ck_fall;
      spi_cs_n <= mode_spi ? sync2_q[SY_SD] : 1'b1; // RULE_02
      spi_active <= mode_spi; // RULE_01
    end
  end

  // wake, event input, spare I/O and amplifier
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake_req <= 1'b0;
      event_mark <= 1'b0;
      external_event_input_o <= 1'b0;
      external_event_input_oe_n <= 1'b1;
      external_event_input_pullup_en <= 1'b1;
      spare_general_io_in <= 1'b1;
      amplifier_enable <= 1'b0;
    end else begin
      wake_req <= power_save && ((mode_uart && rx_change) || ev_edge); // RULE_10 RULE_13
      event_mark <= ev_edge; // RULE_13
      external_event_input_o <= spare_general_io_out;
      external_event_input_oe_n <= ev_oe_n_d; // RULE_12
      // the host must hold the level itself once the pull-up is gone
      external_event_input_pullup_en <= (ext_mode != EXT_ONOFF); // RULE_14 RULE_11
      spare_general_io_in <= ev_used ? 1'b1 : sync2_q[SY_EV]; // RULE_12
      amplifier_enable <= amp_d; // RULE_15
    end
  end

  // one indicator per port, never shared
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_txr
      hps_txr_if #(.CW(CW)) txr_bus ();
      assign txr_bus.enable = txr_enable[gi]; // RULE_05
      assign txr_bus.polarity = txr_polarity[gi];
      assign txr_bus.port_on = (gi == PORT_SPI) ? mode_spi : mode_uart; // RULE_04
      assign txr_bus.threshold = txr_threshold[gi*CW +: CW];
      assign txr_bus.count = tx_count[gi*CW +: CW];
      assign txr_pin_o[gi] = txr_bus.level;
      assign txr_pin_oe_n[gi] = txr_bus.drive_n;
      hps_txready u_txready (
        .ref_clk(ref_clk),
        .rst(rst),
        .txr(txr_bus.ind)
      );
    end
  endgenerate

endmodule

/* sim/hps_chk.sv */
// assertions on the host port select top ports
// assumes binding to hps_port_select; sees its ports only
`timescale 1ns/10ps
module hps_chk (
  // clock and reset
  input logic ref_clk,
  input logic rst,
  // mode and pins
  input logic uart_active,
  input logic i2c_active,
  input logic spi_active,
  input logic pin_txd_o,
  input logic pin_txd_oe_n,
  input logic uart_tx,
  input logic [3:0] pin_pullup_en,
  // control and status
  input logic [1:0] ext_mode,
  input logic [1:0] power_mode,
  input logic external_event_input_pullup_en,
  input logic rf_on,
  input logic amplifier_enable,
  input logic baud_wr,
  input logic [15:0] baud_div_in,
  input logic [15:0] baud_div,
  input logic [2:0] txr_enable,
  input logic [2:0] txr_pin_oe_n,
  input logic power_save,
  input logic pin_rxd_i,
  input logic wake_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // mode outputs only settle on the second edge after release
  property p_mode; !$past(rst) && !$past(rst, 2) |-> (uart_active ^ spi_active) && i2c_active == uart_active; endproperty
  a_mode: assert property (p_mode) else $error("mode outputs not exclusive");
  property p_txd; uart_active && $past(uart_active) |-> !pin_txd_oe_n && pin_txd_o == $past(uart_tx); endproperty
  a_txd: assert property (p_txd) else $error("txd pin does not follow uart");
  property p_pull; pin_pullup_en == 4'hF; endproperty
  a_pull: assert property (p_pull) else $error("shared pin pull-up off");
  property p_epull; !$past(rst) && $stable(ext_mode) |-> external_event_input_pullup_en == (ext_mode != 2'h2); endproperty
  a_epull: assert property (p_epull) else $error("event pull-up wrong");
  property p_amp;
    !$past(rst) |-> amplifier_enable == ($past(power_mode) == 2'h0 || ($past(power_mode) == 2'h1 && $past(rf_on)));
  endproperty
  a_amp: assert property (p_amp) else $error("amplifier enable wrong");
  property p_baud; baud_wr |-> ##2 baud_div == $past(baud_div_in, 2); endproperty
  a_baud: assert property (p_baud) else $error("divider not loaded");
  property p_txr; $past(txr_enable, 2) == 3'h0 |-> txr_pin_oe_n == 3'h7; endproperty
  a_txr: assert property (p_txr) else $error("disabled indicator driven");
  property p_wake; power_save && uart_active && $changed(pin_rxd_i) |-> ##[1:5] wake_req; endproperty
  a_wake: assert property (p_wake) else $error("no wake on rx change");
  c_wake: cover property (uart_active && wake_req);
  c_baud: cover property (baud_wr ##2 1'b1);
  c_txr: cover property (txr_pin_oe_n != 3'h7);
endmodule
bind hps_port_select hps_chk i_chk (.*);

/* sim/hps_host.sv */
// host model: frames traffic on the shared data and clock pins
// assumes the bench starts a frame with a rising go and waits on busy
`timescale 1ns/10ps
module hps_host (
  // frame request
  input logic go,
  output logic busy,
  // host pins; clock idles low outside frames, data idles on the pull-up
  output logic sck,
  output logic cs_n,
  output logic mosi
);
  initial begin
    busy = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end
  always @(posedge go) begin
    busy = 1'b1;
    #33 cs_n = 1'b0;
    for (int i = 0; i < 4; i++) begin
      mosi = i[0];
      #80 sck = 1'b1;
      #80 sck = 1'b0;
    end
    #40 cs_n = 1'b1;
    mosi = 1'b1;
    busy = 1'b0;
  end
endmodule

/* sim/testbench.sv */
// self-checking bench for the host port select block
// assumes hps_host plays the host; strap is driven by the bench
`timescale 1ns/10ps
module testbench;
  import hps_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, iface_sel_i = 1'b1, go = 1'b0, busy, sck, cs_n, mosi;
  logic pin_txd_o, pin_txd_oe_n, pin_sda_o, pin_sda_oe_n, uart_tx = 1'b1, uart_rx, uart_active;
  logic [3:0] pin_pullup_en;
  logic baud_wr = 1'b0, i2c_sda_pull_low = 1'b0, i2c_scl, i2c_sda, i2c_active, spi_miso = 1'b0;
  logic [15:0] baud_div_in = 16'h0000, baud_div;
  logic spi_mosi, spi_sck, spi_sck_rise, spi_sck_fall, spi_cs_n, spi_active;
  logic [2:0] txr_enable = 3'h0, txr_polarity = 3'h0, txr_pin_o, txr_pin_oe_n;
  logic [23:0] txr_threshold = 24'h0, tx_count = 24'h0;
  logic power_save = 1'b0, rf_on = 1'b0, wake_req, amplifier_enable, event_mark;
  logic [1:0] power_mode = 2'h0, ext_mode = 2'h0;
  logic external_event_input_i = 1'b1, external_event_input_o, external_event_input_oe_n;
  logic external_event_input_pullup_en, spare_general_io_out = 1'b0, spare_general_io_drive = 1'b0;
  logic spare_general_io_in;
  wire pin_rxd_i = mosi;
  wire pin_clk_i = sck;
  // open-drain data line with pull-up
  wire pin_sda_i = cs_n & (pin_sda_oe_n | pin_sda_o);
  int errors = 0, n_tests = 0, n_rise = 0, n_wake = 0, n_mark = 0, n_fall = 0, n_miso = 0;
  logic [3:0] rx_bits = 4'h0;
  hps_port_select i_dut (.*);
  hps_host i_host (.go(go), .busy(busy), .sck(sck), .cs_n(cs_n), .mosi(mosi));
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    n_rise += int'(spi_sck_rise);
    n_wake += int'(wake_req);
    n_mark += int'(event_mark);
    n_fall += int'(spi_sck_fall);
    n_miso += int'(!pin_txd_oe_n && pin_txd_o);
    if (spi_sck_rise) rx_bits = {rx_bits[2:0], spi_mosi};
  end
  task tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task do_reset(input logic sel);
    iface_sel_i = sel;
    rst = 1'b1;
    tick(12);
    rst = 1'b0;
    tick(4);
  endtask
  // one host frame, bounded wait on the model
  task frame;
    go = 1'b1;
    tick();
    go = 1'b0;
    for (int k = 0; k < 300 && busy; k++) tick();
    if (busy) begin
      errors++;
      finish_test();
    end
    tick(6);
  endtask
  task t_uart;
    do_reset(1'b1);
    chk({uart_active, i2c_active, spi_active}, 24'h6);
    chk(baud_div, 24'(UART_BAUD_DIV_DEFAULT));
    chk(txr_pin_oe_n, 24'h7);
    baud_div_in = 16'h01A0;
    baud_wr = 1'b1;
    tick();
    baud_wr = 1'b0;
    tick(2);
    chk(baud_div, 24'h1A0);
    uart_tx = 1'b0;
    tick(2);
    chk({pin_txd_o, pin_txd_oe_n}, 24'h0);
    i2c_sda_pull_low = 1'b1;
    tick(5);
    chk({pin_sda_oe_n, pin_sda_o, i2c_sda}, 24'h0);
    i2c_sda_pull_low = 1'b0;
    tick(4);
    power_save = 1'b1;
    n_rise = 0;
    n_wake = 0;
    frame();
    power_save = 1'b0;
    chk(24'(n_rise), 24'h0);
    chk(24'(n_wake > 0), 24'h1);
    $display("uart test done");
  endtask
  task t_txr_ext;
    txr_enable = 3'h1;
    txr_polarity = 3'h1;
    txr_threshold = 24'h4;
    tx_count = 24'h3;
    tick(3);
    chk({txr_pin_oe_n[0], txr_pin_o[0]}, 24'h0);
    tx_count = 24'h4;
    tick(2);
    chk(txr_pin_o[0], 24'h1);
    tx_count = 24'h2;
    tick(2);
    chk(txr_pin_o[0], 24'h0);
    txr_polarity = 3'h0;
    tx_count = 24'h4;
    tick(3);
    chk(txr_pin_o[0], 24'h0);
    spare_general_io_drive = 1'b1;
    spare_general_io_out = 1'b1;
    external_event_input_i = 1'b0;
    tick(4);
    chk({external_event_input_oe_n, external_event_input_o, spare_general_io_in}, 24'h2);
    chk(24'(n_mark), 24'h0);
    spare_general_io_drive = 1'b0;
    ext_mode = 2'h1;
    power_save = 1'b1;
    tick();
    n_wake = 0;
    external_event_input_i = 1'b1;
    tick(6);
    chk({16'h0, 4'(n_mark), 4'(n_wake)}, 24'h11);
    ext_mode = 2'h2;
    tick(2);
    chk(external_event_input_pullup_en, 24'h0);
    power_save = 1'b0;
    for (int k = 0; k < 8; k++) begin
      power_mode = 2'(k >> 1);
      rf_on = k[0];
      tick(2);
      chk(amplifier_enable, 24'(k < 2 || k == 3));
    end
    $display("indicator and event test done");
  endtask
  task t_spi;
    do_reset(1'b0);
    chk({uart_active, i2c_active, spi_active}, 24'h1);
    txr_enable = 3'h7;
    tick(3);
    chk(txr_pin_oe_n, 24'h3);
    spi_miso = 1'b1;
    n_rise = 0;
    n_fall = 0;
    n_miso = 0;
    frame();
    chk({16'h0, 4'(n_rise), 4'(spi_cs_n)}, 24'h41);
    chk({16'h0, 4'(n_fall), rx_bits}, 24'h45);
    chk(24'(n_miso > 0), 24'h1);
    chk({pin_txd_oe_n, uart_rx, i2c_scl, i2c_sda}, 24'hF);
    $display("spi test done");
  endtask
  initial begin
    t_uart();
    t_txr_ext();
    t_spi();
    finish_test();
  end
endmodule
